/* File: logic/sar_adc_sequencer.sv */
// successive-approximation converter sequencer with avalon registers
//
// Contract
// - convert sampled input by successive approximation to 8-bit unsigned
// - bits 5:3 pick input channel, codes 0 to 4
// - conversion period is 2, 8 or 32 clocks, or RC oscillator
// - reference is supply or the external reference pin
// - completion loads result, clears start bit, sets done flag
// - reset returns registers, turns converter off, aborts conversion
// - result register keeps no reset value
// - a conversion lasts nine and a half conversion periods
// - conversion runs in sleep only with RC clock
// - pin register sets pins analog, digital, or reference input
`timescale 1ns/1ns
`include "sar_adc_map.svh"

module sar_adc_sequencer (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // avalon-mm slave
    input  wire sar_adc_pkg::av_req_t      bus_req,
    output logic [31:0]                    readdata,
    output logic                           waitrequest,
    // analog side and oscillator
    input  wire logic                      comparator_hi,
    input  wire logic                      rc_osc,
    input  wire logic                      sleep_mode,
    output sar_adc_pkg::analog_out_t       ana,
    // interrupt
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // word address match
    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        return (a[1:0] == 2'h0) && (a[9:2] == idx);
    endfunction : hit

    // clk cycles per half conversion period
    function automatic logic [4:0] half_len(input logic [1:0] sel);
        unique case (sel)
            `SEL_DIV2:  return `HALF_DIV2;
            `SEL_DIV8:  return `HALF_DIV8;
            default:    return `HALF_DIV32;
        endcase
    endfunction : half_len

    // pin function decode: reference source and analog pin mask
    function automatic logic [5:0] pin_map(input logic [2:0] cfg);
        unique case (cfg)
            3'h0:    return 6'h1F;
            3'h1:    return 6'h37;
            3'h2:    return 6'h0F;
            3'h3:    return 6'h27;
            3'h4:    return 6'h0B;
            3'h5:    return 6'h23;
            default: return 6'h00;
        endcase
    endfunction : pin_map

    ////////////////////////////////////////////////////////////////////////
    // state

    sar_adc_pkg::state_t st;
    sar_adc_pkg::state_t next_st;
    logic [7:0]          conversion_result;
    logic                busy;
    logic                tick;
    logic                done;
    logic                acc;
    logic [2:0]          bit_pos;
    logic [5:0]          pins;

    assign busy = st.phase == sar_adc_pkg::PH_CONV;
    assign acc  = bus_req.write && st.ack && bus_req.byteenable[0];
    assign pins = pin_map(st.pcfg);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        next_st = st;
        tick    = 1'b0;
        done    = 1'b0;
        bit_pos = 3'(4'h8 - {1'b0, st.halfcnt[4:1]});
        // pin synchronisers
        next_st.rc_s1  = rc_osc;
        next_st.rc_s2  = st.rc_s1;
        next_st.rc_s3  = st.rc_s2;
        next_st.cmp_s1 = comparator_hi;
        next_st.cmp_s2 = st.cmp_s1;
        // one wait state per access
        next_st.ack = (bus_req.read || bus_req.write) && !st.ack;
        if (bus_req.read && !st.ack)
        begin
            next_st.rdata = 32'h0000_0000;
            if (hit(bus_req.address, `IDX_RESULT))
                next_st.rdata[7:0] = conversion_result;
            if (hit(bus_req.address, `IDX_CTRL))
            begin
                next_st.rdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB]   = st.clk_sel;
                next_st.rdata[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB] = st.chan;
                next_st.rdata[`CTRL_GO] = busy;
                next_st.rdata[`CTRL_ON] = st.power_on;
            end
            if (hit(bus_req.address, `IDX_PINCFG))
                next_st.rdata[`PINCFG_MSB:0] = st.pcfg;
            if (hit(bus_req.address, `IDX_IRQ_STATUS))
                next_st.rdata[`STAT_DONE] = st.done_flag;
            if (hit(bus_req.address, `IDX_IRQ_MASK))
                next_st.rdata[`STAT_DONE] = st.done_mask;
        end
        // register writes
        if (acc && hit(bus_req.address, `IDX_CTRL))
        begin
            next_st.clk_sel  = bus_req.writedata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
            next_st.chan     = bus_req.writedata[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
            next_st.power_on = bus_req.writedata[`CTRL_ON];
            if (bus_req.writedata[`CTRL_GO] && st.power_on && !busy)
            begin
                next_st.phase   = sar_adc_pkg::PH_CONV;
                next_st.halfcnt = 5'h00;
                next_st.divcnt  = 5'h00;
                next_st.trial   = 8'h00;
            end
        end
        if (acc && hit(bus_req.address, `IDX_PINCFG))
            next_st.pcfg = bus_req.writedata[`PINCFG_MSB:0];
        if (acc && hit(bus_req.address, `IDX_IRQ_MASK))
            next_st.done_mask = bus_req.writedata[`STAT_DONE];
        if (acc && hit(bus_req.address, `IDX_IRQ_STATUS)
            && bus_req.writedata[`STAT_DONE])
            next_st.done_flag = 1'b0;
        // half-period tick generator
        // oscillator clocks stall in sleep, RC keeps running
        if (busy && (!sleep_mode || st.clk_sel == `SEL_RC))
        begin
            // code 11 takes RC edges, others divide clk
            if (st.clk_sel == `SEL_RC)
                tick = st.rc_s2 != st.rc_s3;
            else if (st.divcnt == half_len(st.clk_sel) - 5'h01)
            begin
                tick           = 1'b1;
                next_st.divcnt = 5'h00;
            end
            else
                next_st.divcnt = st.divcnt + 5'h01;
        end
        // successive approximation steps
        if (tick)
        begin
            // open the sampler, try the top bit
            if (st.halfcnt == 5'h00)
                next_st.trial = 8'h80;
            else if (!st.halfcnt[0] && st.halfcnt <= `LAST_BIT_HALF)
            begin
                // keep or drop the bit, try the next
                if (!st.cmp_s2)
                    next_st.trial[bit_pos] = 1'b0;
                if (bit_pos != 3'h0)
                    next_st.trial[bit_pos - 3'h1] = 1'b1;
            end
            if (st.halfcnt == `CONV_LAST_HALF)
            begin
                // finish: clear busy, flag wins over clear
                done              = 1'b1;
                next_st.phase     = sar_adc_pkg::PH_IDLE;
                next_st.done_flag = 1'b1;
            end
            else
                next_st.halfcnt = st.halfcnt + 5'h01;
        end
        if (!next_st.power_on)
            next_st.phase = sar_adc_pkg::PH_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st           <= '0;
            st.clk_sel   <= `CTRL_SEL_RESET;
            st.chan      <= `CTRL_CHAN_RESET;
            st.pcfg      <= `PINCFG_RESET;
            st.phase     <= sar_adc_pkg::PH_IDLE;
        end
        else
            st <= next_st;
    end

    // result without reset, loaded on completion
    always_ff @(posedge clk)
    begin
        if (done)
            conversion_result <= st.trial;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // bus answer and analog drive
    assign waitrequest      = (bus_req.read || bus_req.write) && !st.ack;
    assign readdata         = st.rdata;
    assign ana.channel      = st.chan;
    assign ana.ref_from_pin = pins[5];
    assign ana.analog_pins  = pins[4:0];
    assign ana.sample       = st.power_on && !busy;
    assign ana.power        = st.power_on;
    assign ana.trial        = st.trial;
    assign irq              = st.done_flag && st.done_mask;

    ////////////////////////////////////////////////////////////////////////
    // assertion helpers: cycles in conversion, sleep seen

    logic [8:0] cyc;
    logic       slept;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cyc   <= 9'h000;
            slept <= 1'b0;
        end
        else if (!busy)
        begin
            cyc   <= 9'h000;
            slept <= 1'b0;
        end
        else
        begin
            cyc   <= cyc + 9'h001;
            slept <= slept || sleep_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    result_load_a: assert property (done |=>
        conversion_result == $past(st.trial) && !busy && st.done_flag)
        else $error("result or flag not set at completion");

    start_conv_a: assert property (acc && hit(bus_req.address, `IDX_CTRL)
        && bus_req.writedata[`CTRL_GO] && bus_req.writedata[`CTRL_ON]
        && st.power_on && !busy |=> busy)
        else $error("start write did not begin conversion");

    no_early_go_a: assert property (!st.power_on && acc
        && hit(bus_req.address, `IDX_CTRL) |=> !busy)
        else $error("conversion started while converter was off");

    off_abort_a: assert property (!st.power_on |-> !busy && !ana.sample)
        else $error("converter active while off");

    enable_off_a: assert property (acc && hit(bus_req.address, `IDX_CTRL)
        && !bus_req.writedata[`CTRL_ON] |=> !ana.power && !busy)
        else $error("enable write of zero left converter on");

    conv_length_a: assert property (done && !slept && st.clk_sel != `SEL_RC
        |-> cyc == 9'h013 * {4'h0, half_len(st.clk_sel)} - 9'h001)
        else $error("conversion length wrong");

    div_pace_a: assert property (busy && !sleep_mode && st.clk_sel != `SEL_RC
        && st.divcnt != half_len(st.clk_sel) - 5'h01 |=> $stable(st.halfcnt))
        else $error("conversion advanced before divider ran out");

    sleep_stall_a: assert property (busy && sleep_mode
        && st.clk_sel != `SEL_RC |=> $stable(st.halfcnt))
        else $error("conversion advanced in sleep without rc");

    rc_sleep_run_a: assert property (busy && sleep_mode && st.clk_sel == `SEL_RC
        && st.rc_s2 != st.rc_s3 |=> !busy || st.halfcnt != $past(st.halfcnt))
        else $error("rc conversion stalled in sleep");

    rc_step_a: assert property (busy && st.clk_sel == `SEL_RC
        && st.rc_s2 == st.rc_s3 |=> $stable(st.halfcnt))
        else $error("rc conversion advanced without rc edge");

    trial_start_a: assert property (tick && st.halfcnt == 5'h00
        |=> ana.trial == 8'h80)
        else $error("first trial code is not the top bit");

    hold_open_a: assert property (busy |-> !ana.sample
        ##1 (busy || st.done_flag || !st.power_on))
        else $error("sampler tracking during conversion");

    flag_clear_a: assert property (acc && hit(bus_req.address, `IDX_IRQ_STATUS)
        && bus_req.writedata[`STAT_DONE] && !done |=> !st.done_flag && !irq)
        else $error("done flag not cleared by write one");

    go_readback_a: assert property (bus_req.read && !st.ack
        && hit(bus_req.address, `IDX_CTRL) |=> readdata[`CTRL_GO] == $past(busy))
        else $error("start bit read back wrong");

    bus_wait_a: assert property ((bus_req.read || bus_req.write) && waitrequest
        |=> !waitrequest)
        else $error("access waited more than one cycle");

    // main scenarios
    conv_done_c: cover property (done);
    rc_done_c: cover property (done && st.clk_sel == `SEL_RC);
    irq_c: cover property (irq ##[1:20] !irq);
    abort_c: cover property (busy ##1 !busy && !st.done_flag);
    sleep_freeze_c: cover property (busy && sleep_mode && st.clk_sel != `SEL_RC);

endmodule : sar_adc_sequencer

/* File: logic/sar_adc_map.svh */
// register indices, field positions, reset values and timing counts
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// register indices; byte address is four times the index
`define IDX_RESULT      8'h1E
`define IDX_CTRL        8'h1F
`define IDX_PINCFG      8'h9F
`define IDX_IRQ_STATUS  8'hA0
`define IDX_IRQ_MASK    8'hA1

// control register fields
`define CTRL_SEL_MSB    7
`define CTRL_SEL_LSB    6
`define CTRL_CHAN_MSB   5
`define CTRL_CHAN_LSB   3
`define CTRL_GO         2
`define CTRL_ON         0

// pin function and interrupt fields
`define PINCFG_MSB      2
`define STAT_DONE       0

// reset values
`define CTRL_SEL_RESET  2'h0
`define CTRL_CHAN_RESET 3'h0
`define PINCFG_RESET    3'h0

// conversion clock codes and half-period lengths in clk cycles
`define SEL_DIV2        2'h0
`define SEL_DIV8        2'h1
`define SEL_DIV32       2'h2
`define SEL_RC          2'h3
`define HALF_DIV2       5'h01
`define HALF_DIV8       5'h04
`define HALF_DIV32      5'h10

// 9.5 periods are 19 half periods, counted 0 to 18
`define CONV_LAST_HALF  5'h12
`define LAST_BIT_HALF   5'h10

`endif

/* File: logic/sar_adc_pkg.sv */
// types shared by the converter sequencer
package sar_adc_pkg;

    // sequencer phases, one-hot
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_CONV = 2'b10
    } phase_t;

    // avalon request from the master
    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } av_req_t;

    // drive towards the analog sampler and converter
    typedef struct packed {
        logic [2:0] channel;
        logic       ref_from_pin;
        logic [4:0] analog_pins;
        logic       sample;
        logic       power;
        logic [7:0] trial;
    } analog_out_t;

    // state of the sequencer except the result register
    typedef struct packed {
        logic [1:0]  clk_sel;
        logic [2:0]  chan;
        logic        power_on;
        logic [2:0]  pcfg;
        logic        done_flag;
        logic        done_mask;
        logic        ack;
        logic [31:0] rdata;
        phase_t      phase;
        logic [4:0]  halfcnt;
        logic [4:0]  divcnt;
        logic [7:0]  trial;
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
        logic        cmp_s1;
        logic        cmp_s2;
    } state_t;

endpackage : sar_adc_pkg

/* File: tb/analog_model.sv */
// behavioural comparator and rc oscillator beside the sequencer, level compared directly with no sampler
`timescale 1ns/1ns

module analog_model (
    // drive from the sequencer and level from the bench
    input  wire sar_adc_pkg::analog_out_t ana,
    input  wire logic [7:0]               level,
    // answers to the sequencer
    output logic                          comparator_hi,
    output logic                          rc_osc
);

    ////////////////////////////////////////////////////////////////////////////////
    // free running rc oscillator, 40 ns per half period
    initial
    begin
        rc_osc = 1'b0;
        forever #40 rc_osc = ~rc_osc;
    end

    // level only enters the model, never driven back
    // comparator; unpowered it shows a changing pattern, not a held level
    // trial compare
    always_comb comparator_hi = ana.power ? (level >= ana.trial) : rc_osc;

endmodule : analog_model

/* File: tb/tb.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns

module tb;

    typedef struct {
        logic [1:0] sel;
        logic [2:0] chan;
        logic [7:0] lvl;
        int         cyc;
    } row_t;

    localparam logic [9:0] RES = 10'h078;
    localparam logic [9:0] CTL = 10'h07C;
    localparam logic [9:0] PIN = 10'h27C;
    localparam logic [9:0] STA = 10'h280;
    localparam logic [9:0] MSK = 10'h284;

    logic                     clk = 1'b0;
    logic                     reset;
    logic                     sleep_mode;
    logic                     comparator_hi;
    logic                     rc_osc;
    logic                     waitrequest;
    logic                     irq;
    logic [31:0]              readdata;
    logic [31:0]              rd;
    logic [7:0]               level;
    sar_adc_pkg::av_req_t     bus_req;
    sar_adc_pkg::analog_out_t ana;
    int                       fails;
    int                       check_count;
    int                       n;
    // every source but the divide-by-2 clock suits the instantly settling partner
    // zero cycle count means rc clock, length not fixed
    row_t rows[6] = '{'{2'h0, 3'h0, 8'h00, 19}, '{2'h1, 3'h1, 8'h5A, 76},
                      '{2'h2, 3'h4, 8'hFF, 304}, '{2'h2, 3'h2, 8'h00, 304},
                      '{2'h3, 3'h3, 8'hA5, 0}, '{2'h1, 3'h3, 8'h80, 76}};
    logic [4:0] pm[8] = '{5'h1F, 5'h17, 5'h0F, 5'h07, 5'h0B, 5'h03, 5'h00, 5'h00};

    ////////////////////////////////////////////////////////////////////////////////
    // design and analog partner
    sar_adc_sequencer u_dut (.clk(clk), .reset(reset), .bus_req(bus_req),
        .readdata(readdata), .waitrequest(waitrequest), .comparator_hi(comparator_hi),
        .rc_osc(rc_osc), .sleep_mode(sleep_mode), .ana(ana), .irq(irq));
    analog_model u_ana (.ana(ana), .level(level), .comparator_hi(comparator_hi),
        .rc_osc(rc_osc));

    // clock
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus_op(input logic wr, input logic [9:0] a, input logic [31:0] d);
        int   k;
        logic w;
        k = 0;
        w = 1'b1;
        @(posedge clk);
        bus_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
        do
        begin
            // settled mid-cycle, stands until the rising edge that ends it
            @(negedge clk);
            w  = waitrequest;
            rd = readdata;
            @(posedge clk);
            k++;
        end
        while (w !== 1'b0 && k < 50);
        if (w !== 1'b0)
            fails++;
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
    endtask : bus_op

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // cycles until the sampler tracks again
    task automatic wait_idle(output int c);
        c = 0;
        do
        begin
            @(negedge clk);
            c++;
        end
        while (ana.sample !== 1'b1 && c < 2000);
        if (ana.sample !== 1'b1)
            fails++;
    endtask : wait_idle

    // verdict
    task automatic tally_and_finish();
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial
    begin
        #400000;
        fails++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        reset = 1'b1;
        sleep_mode = 1'b0;
        level = 8'h00;
        bus_req = '0;
        fails = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // reset values and unmapped place
        bus_op(0, CTL, 0);
        chk(rd, 32'h00);
        bus_op(0, PIN, 0);
        chk(rd, 32'h00);
        bus_op(0, 10'h3F0, 0);
        chk(rd, 32'h00);
        chk(ana.power, 1'b0);
        // start while off, and start in the enabling write, are refused
        bus_op(1, CTL, 32'h04);
        bus_op(0, CTL, 0);
        chk(rd, 32'h00);
        bus_op(1, CTL, 32'h05);
        bus_op(0, CTL, 0);
        chk(rd, 32'h01);
        // pin function decode
        for (int p = 0; p < 8; p++)
        begin
            bus_op(1, PIN, p);
            @(posedge clk);
            chk(ana.analog_pins, pm[p]);
            chk(ana.ref_from_pin, p[0] && p < 6);
        end
        bus_op(1, MSK, 32'h01);
        // configure, enable, start, poll, read, clear
        // ordinary conversions, one per row
        foreach (rows[i])
        begin
            level <= rows[i].lvl;
            bus_op(1, CTL, {24'h0, rows[i].sel, rows[i].chan, 3'b001});
            bus_op(1, CTL, {24'h0, rows[i].sel, rows[i].chan, 3'b101});
            chk(ana.channel, rows[i].chan);
            wait_idle(n);
            if (rows[i].cyc != 0)
                chk(n, rows[i].cyc + 1);
            bus_op(0, RES, 0);
            if (rows[i].sel != 2'h0)
            begin
                chk(rd, rows[i].lvl);
                chk(ana.trial, rows[i].lvl);
            end
            bus_op(0, CTL, 0);
            chk(rd, {24'h0, rows[i].sel, rows[i].chan, 3'b001});
            chk(irq, 1'b1);
            bus_op(1, STA, 32'h01);
            @(posedge clk);
            chk(irq, 1'b0);
            repeat (64) @(posedge clk);
        end
        // oscillator clock frozen in sleep, resumes on wake
        level <= 8'h3C;
        sleep_mode <= 1'b1;
        bus_op(1, CTL, 32'h49);
        bus_op(1, CTL, 32'h4D);
        bus_op(0, CTL, 0);
        chk(rd, 32'h4D);
        repeat (100) @(posedge clk);
        chk(ana.sample, 1'b0);
        sleep_mode <= 1'b0;
        wait_idle(n);
        bus_op(0, RES, 0);
        chk(rd, 32'h3C);
        // rc clock runs in sleep
        sleep_mode <= 1'b1;
        bus_op(1, CTL, 32'hC1);
        bus_op(1, CTL, 32'hC5);
        wait_idle(n);
        bus_op(0, RES, 0);
        chk(rd, 32'h3C);
        sleep_mode <= 1'b0;
        bus_op(1, STA, 32'h01);
        // switching off mid conversion aborts it
        bus_op(1, CTL, 32'h81);
        bus_op(1, CTL, 32'h85);
        repeat (50) @(posedge clk);
        bus_op(1, CTL, 32'h00);
        bus_op(0, CTL, 0);
        chk(rd, 32'h00);
        bus_op(0, STA, 0);
        chk(rd, 32'h00);
        chk(ana.power, 1'b0);
        // reset mid conversion
        bus_op(1, CTL, 32'h81);
        bus_op(1, CTL, 32'h85);
        repeat (30) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus_op(0, CTL, 0);
        chk(rd, 32'h00);
        chk(ana.power, 1'b0);
        chk(irq, 1'b0);
        tally_and_finish();
    end

endmodule : tb
